/* rtl/acquisition_trigger_sequencer.sv */
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// Functional notes
// - Continuous mode with both stages off makes all events internally and runs without pause.
// - Internal frames are paced at the programmed period unless the pipeline is slower.
// - With pacing disabled, internal frames start as soon as the pipeline is ready.
// - With the burst stage off every burst opens internally.
// - With the frame stage on a frame starts only on a frame trigger, one per frame.
// - The frame trigger comes from the selected line on the selected edge.
// - With the burst stage on, the selected edge moves waiting-burst to waiting-frame.
// - With the burst stage on, after a nonzero programmed frame count the sequencer returns to waiting for a burst.
// - With the burst stage on, no frame starts after a burst ends until a fresh burst edge arrives.
// - Frame triggers are ignored while waiting for a burst.
// - With bursts external and frame stage off, frames are paced internally.
module acquisition_trigger_sequencer (
   // Clock and reset
   input  wire logic                              sys_clk_i,
   input  wire logic                              rst_b_i,
   // Avalon-MM slave
   input  wire logic [acq_seq_pkg::ADDR_W-1:0]    avs_address_i,
   input  wire logic                              avs_read_i,
   input  wire logic                              avs_write_i,
   input  wire logic [acq_seq_pkg::DATA_W-1:0]    avs_writedata_i,
   input  wire logic [acq_seq_pkg::BE_W-1:0]      avs_byteenable_i,
   output logic [acq_seq_pkg::DATA_W-1:0]         avs_readdata_o,
   output logic                                   avs_waitrequest_o,
   // Trigger input lines
   input  wire logic [acq_seq_pkg::LINES-1:0]     trig_line_i,
   // Sensor pipeline
   input  wire logic                              frame_ready_i,
   output logic                                   frame_start_o,
   output logic                                   burst_start_o,
   // Acquisition status
   output logic                                   wait_acq_o,
   output logic                                   wait_frame_o
);
   import acq_seq_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0]   rdata;
      logic                waitreq;
      logic [CTRL_W-1:0]   ctrl;
      logic [BURST_W-1:0]  burst_len;
      logic                rate_en;
      logic [PERIOD_W-1:0] period;
      seq_state_t          state;
      logic [BURST_W-1:0]  burst_cnt;
      logic [DATA_W-1:0]   total;
      logic                frame_start;
      logic                burst_start;
      logic                wait_acq;
      logic                wait_frame;
   } seq_reg_t;

   seq_reg_t st;
   seq_reg_t next_st;

   logic [LINES-1:0] line_rise;
   logic [LINES-1:0] line_fall;
   logic             pace_elapsed;

   // ==========================================================================
   // Per-line synchronisers and edge detectors
   genvar g;
   generate
      for (g = 0; g < LINES; g++) begin : g_line
         trig_edge_detect u_edge (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .line_i    (trig_line_i[g]),
            .rise_o    (line_rise[g]),
            .fall_o    (line_fall[g])
         );
      end
   endgenerate

   // ==========================================================================
   // Internal frame pacing
   frame_pacer u_pacer (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .restart_i (next_st.frame_start),
      .period_i  (st.period),
      .elapsed_o (pace_elapsed)
   );

   // ==========================================================================
   // Helpers
   function automatic logic pick_edge(input logic [LINES-1:0] rise,
                                      input logic [LINES-1:0] fall,
                                      input logic             src,
                                      input logic [1:0]       act);
      logic r;
      logic f;
      r = rise[src];
      f = fall[src];
      unique case (act)
         ACT_RISE: pick_edge = r;
         ACT_FALL: pick_edge = f;
         ACT_ANY:  pick_edge = r | f;
         default:  pick_edge = 1'b0;
      endcase
   endfunction : pick_edge

   function automatic logic [DATA_W-1:0] merge_be(input logic [DATA_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] new_v,
                                                 input logic [BE_W-1:0]   be);
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_be

   // ==========================================================================
   // Next-state logic
   logic              acq_edge;
   logic              frm_edge;
   logic              frm_trig;
   logic              acq_en;
   logic              acq_trig_on;
   logic              frm_trig_on;
   logic [2:0]        widx;
   logic [DATA_W-1:0] wmerge;
   logic [DATA_W-1:0] rmux;
   logic [BURST_W-1:0] cnt_inc;

   always_comb begin
      next_st             = st;
      next_st.frame_start = 1'b0;
      next_st.burst_start = 1'b0;
      widx                = avs_address_i[4:2];
      wmerge              = '0;
      rmux                = '0;
      cnt_inc             = st.burst_cnt + {{(BURST_W-1){1'b0}}, 1'b1};

      // Fixed one wait state: request seen, then answered at the next edge
      next_st.waitreq = ~((avs_read_i | avs_write_i) & st.waitreq);

      unique case (widx)
         REG_CTRL:   rmux = {{(DATA_W-CTRL_W){1'b0}}, st.ctrl};
         REG_BURST:  rmux = {{(DATA_W-BURST_W){1'b0}}, st.burst_len};
         REG_RATE:   rmux = {st.rate_en, {(DATA_W-PERIOD_W-1){1'b0}}, st.period};
         REG_STATUS: rmux = {st.burst_cnt, {(STAT_BURST_CNT-STAT_READY-1){1'b0}},
                             frame_ready_i, st.state};
         REG_TOTAL:  rmux = st.total;
         default:    rmux = '0;
      endcase
      if (avs_read_i && st.waitreq) begin
         next_st.rdata = rmux;
      end

      // Writes commit at the edge where waitrequest is seen low
      if (avs_write_i && !st.waitreq) begin
         unique case (widx)
            REG_CTRL: begin
               wmerge       = merge_be({{(DATA_W-CTRL_W){1'b0}}, st.ctrl},
                                       avs_writedata_i, avs_byteenable_i);
               next_st.ctrl = wmerge[CTRL_W-1:0];
            end
            REG_BURST: begin
               wmerge            = merge_be({{(DATA_W-BURST_W){1'b0}}, st.burst_len},
                                            avs_writedata_i, avs_byteenable_i);
               next_st.burst_len = wmerge[BURST_W-1:0];
            end
            REG_RATE: begin
               wmerge          = merge_be({st.rate_en, {(DATA_W-PERIOD_W-1){1'b0}},
                                           st.period}, avs_writedata_i, avs_byteenable_i);
               next_st.rate_en = wmerge[RATE_EN];
               next_st.period  = wmerge[PERIOD_W-1:0];
            end
            default: begin
            end
         endcase
      end

      acq_en      = st.ctrl[CTRL_ACQ_EN];
      acq_trig_on = st.ctrl[CTRL_ACQ_TRIG_ON];
      frm_trig_on = st.ctrl[CTRL_FRM_TRIG_ON];
      acq_edge    = pick_edge(line_rise, line_fall, st.ctrl[CTRL_ACQ_SRC],
                              st.ctrl[CTRL_ACQ_ACT +: 2]);
      frm_edge    = pick_edge(line_rise, line_fall, st.ctrl[CTRL_FRM_SRC],
                              st.ctrl[CTRL_FRM_ACT +: 2]);
      // Internal trigger waits for pacing only when pacing is enabled
      frm_trig    = frm_trig_on ? frm_edge
                                : (~st.rate_en | pace_elapsed);

      unique case (st.state)
         ST_IDLE: begin
            if (acq_en) begin
               if (acq_trig_on) begin
                  next_st.state = ST_WAIT_ACQ;
               end else begin
                  next_st.state       = ST_WAIT_FRAME;
                  next_st.burst_start = 1'b1;
                  next_st.burst_cnt   = '0;
               end
            end
         end
         ST_WAIT_ACQ: begin
            // Frame triggers have no effect here
            if (acq_edge || !acq_trig_on) begin
               next_st.state       = ST_WAIT_FRAME;
               next_st.burst_start = 1'b1;
               next_st.burst_cnt   = '0;
            end
         end
         ST_WAIT_FRAME: begin
            // A frame-line edge while the pipeline is busy is dropped, not queued
            if (frm_trig && frame_ready_i) begin
               next_st.frame_start = 1'b1;
               next_st.burst_cnt   = cnt_inc;
               next_st.total       = st.total + {{(DATA_W-1){1'b0}}, 1'b1};
               if (st.burst_len != '0 && cnt_inc == st.burst_len) begin
                  if (acq_trig_on) begin
                     next_st.state = ST_WAIT_ACQ;
                  end else begin
                     next_st.burst_start = 1'b1;
                     next_st.burst_cnt   = '0;
                  end
               end
            end
         end
      endcase

      if (!acq_en) begin
         next_st.state       = ST_IDLE;
         next_st.frame_start = 1'b0;
         next_st.burst_start = 1'b0;
      end

      next_st.wait_acq   = (next_st.state == ST_WAIT_ACQ);
      next_st.wait_frame = (next_st.state == ST_WAIT_FRAME);
   end

   // ==========================================================================
   // State register
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st           <= '0;
         st.waitreq   <= 1'b1;
         st.ctrl      <= CTRL_RST;
         st.burst_len <= BURST_RST;
         st.rate_en   <= RATE_EN_RST;
         st.period    <= PERIOD_RST;
         st.state     <= ST_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata_o    = st.rdata;
   assign avs_waitrequest_o = st.waitreq;
   assign frame_start_o     = st.frame_start;
   assign burst_start_o     = st.burst_start;
   assign wait_acq_o        = st.wait_acq;
   assign wait_frame_o      = st.wait_frame;

endmodule : acquisition_trigger_sequencer

/* include/acq_seq_pkg.sv */
package acq_seq_pkg;

   // ==========================================================================
   // Bus geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;
   localparam int LINES  = 2;

   // ==========================================================================
   // Register word indices (byte address = index * 4)
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_BURST  = 3'h1;
   localparam logic [2:0] REG_RATE   = 3'h2;
   localparam logic [2:0] REG_STATUS = 3'h3;
   localparam logic [2:0] REG_TOTAL  = 3'h4;

   // ==========================================================================
   // Control register fields
   localparam int CTRL_ACQ_EN      = 0;
   localparam int CTRL_ACQ_TRIG_ON = 1;
   localparam int CTRL_FRM_TRIG_ON = 2;
   localparam int CTRL_ACQ_SRC     = 3;
   localparam int CTRL_ACQ_ACT     = 4;
   localparam int CTRL_FRM_SRC     = 6;
   localparam int CTRL_FRM_ACT     = 7;
   localparam int CTRL_W           = 9;
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

   // Edge activation codes
   localparam logic [1:0] ACT_RISE = 2'h0;
   localparam logic [1:0] ACT_FALL = 2'h1;
   localparam logic [1:0] ACT_ANY  = 2'h2;

   // ==========================================================================
   // Burst length and frame pacing
   localparam int BURST_W = 16;
   localparam logic [BURST_W-1:0] BURST_RST = 16'h0001;
   localparam int RATE_EN        = 31;
   localparam int PERIOD_W       = 24;
   localparam logic [PERIOD_W-1:0] PERIOD_RST = 24'h0F4240;
   localparam logic RATE_EN_RST  = 1'b0;

   // ==========================================================================
   // Status register fields
   localparam int STAT_STATE     = 0;
   localparam int STAT_READY     = 2;
   localparam int STAT_BURST_CNT = 16;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_ACQ,
      ST_WAIT_FRAME
   } seq_state_t;

endpackage : acq_seq_pkg

/* rtl/trig_edge_detect.sv */
`timescale 1ns/1ps
module trig_edge_detect (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   // Trigger line
   input  wire logic line_i,
   // Edge pulses
   output logic      rise_o,
   output logic      fall_o
);
   import acq_seq_pkg::*;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic rise;
      logic fall;
   } edge_state_t;

   edge_state_t st;
   edge_state_t next_st;

   // ==========================================================================
   // Two-stage synchroniser, then one-cycle edge pulses
   always_comb begin
      next_st       = st;
      next_st.sync1 = line_i;
      next_st.sync2 = st.sync1;
      next_st.prev  = st.sync2;
      next_st.rise  = st.sync2 & ~st.prev;
      next_st.fall  = ~st.sync2 & st.prev;
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rise_o = st.rise;
   assign fall_o = st.fall;

endmodule : trig_edge_detect

/* rtl/frame_pacer.sv */
`timescale 1ns/1ps
module frame_pacer (
   // Clock and reset
   input  wire logic                              sys_clk_i,
   input  wire logic                              rst_b_i,
   // Control
   input  wire logic                              restart_i,
   input  wire logic [acq_seq_pkg::PERIOD_W-1:0]  period_i,
   // Status
   output logic                                   elapsed_o
);
   import acq_seq_pkg::*;

   typedef struct packed {
      logic [PERIOD_W-1:0] cnt;
      logic                elapsed;
   } pace_state_t;

   pace_state_t st;
   pace_state_t next_st;

   // ==========================================================================
   // Cycles since last frame start, saturating once the period is reached
   always_comb begin
      next_st = st;
      if (restart_i) begin
         next_st.cnt = {{(PERIOD_W-1){1'b0}}, 1'b1};
      end else if (!st.elapsed) begin
         next_st.cnt = st.cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end
      next_st.elapsed = (next_st.cnt >= period_i);
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign elapsed_o = st.elapsed;

endmodule : frame_pacer

/* sim/acq_seq_properties.sv */
`timescale 1ns/1ps
// ==========================================
// Port checker for the trigger sequencer
module acq_seq_properties
   import acq_seq_pkg::*;
(
   // Clock and reset
   input  wire logic                           sys_clk_i,
   input  wire logic                           rst_b_i,
   // Register bus
   input  wire logic [acq_seq_pkg::ADDR_W-1:0] avs_address_i,
   input  wire logic                           avs_read_i,
   input  wire logic                           avs_write_i,
   input  wire logic [acq_seq_pkg::DATA_W-1:0] avs_writedata_i,
   input  wire logic                           avs_waitrequest_o,
   // Lines and pipeline
   input  wire logic [acq_seq_pkg::LINES-1:0]  trig_line_i,
   input  wire logic                           frame_ready_i,
   input  wire logic                           frame_start_o,
   input  wire logic                           burst_start_o,
   input  wire logic                           wait_acq_o,
   input  wire logic                           wait_frame_o
);
   // ==========================================
   // Shadow of the written settings
   logic [CTRL_W-1:0] ctrl;
   logic [15:0]       blen, fcnt, gap;
   logic [23:0]       per;
   logic [3:0]        age;
   logic              ren, ln_d;
   wire cm  = avs_write_i && !avs_waitrequest_o;
   wire sel = ctrl[CTRL_FRM_SRC] ? trig_line_i[1] : trig_line_i[0];
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= CTRL_RST;
         blen <= BURST_RST;
         per  <= PERIOD_RST;
         ren  <= 1'b0;
         fcnt <= 16'h0;
         gap  <= 16'hFFFF;
         ln_d <= 1'b0;
         age  <= 4'hF;
      end else begin
         if (cm && avs_address_i[4:2] == REG_CTRL) ctrl <= avs_writedata_i[CTRL_W-1:0];
         if (cm && avs_address_i[4:2] == REG_BURST) blen <= avs_writedata_i[15:0];
         if (cm && avs_address_i[4:2] == REG_RATE) begin
            ren <= avs_writedata_i[RATE_EN];
            per <= avs_writedata_i[23:0];
         end
         fcnt <= burst_start_o ? 16'h0 : fcnt + {15'h0, frame_start_o};
         gap  <= frame_start_o ? 16'h1 : (gap == 16'hFFFF ? gap : gap + 16'h1);
         ln_d <= sel;
         age  <= (sel && !ln_d) ? 4'h0 : (age == 4'hF ? age : age + 4'h1);
      end
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing");
   state_excl_a: assert property (!(wait_acq_o && wait_frame_o))
      else $error("both wait states");
   burst_open_a: assert property ($past(wait_acq_o) && burst_start_o
      |-> wait_frame_o && !wait_acq_o) else $error("burst edge did not open");
   burst_end_a: assert property (ctrl[CTRL_ACQ_TRIG_ON] && blen != 16'h0
      && frame_start_o && fcnt == blen - 16'h1 |-> wait_acq_o) else $error("burst not closed");
   no_frame_a: assert property (wait_acq_o && $past(wait_acq_o) |-> !frame_start_o)
      else $error("frame while awaiting burst");
   burst_resume_a: assert property ($fell(wait_acq_o) && wait_frame_o |-> burst_start_o)
      else $error("left burst wait without edge");
   frame_edge_a: assert property (ctrl[CTRL_FRM_TRIG_ON] && ctrl[8:7] == ACT_RISE
      && frame_start_o |-> age inside {[1:6]}) else $error("frame without line edge");
   pace_gap_a: assert property (ren && !ctrl[CTRL_FRM_TRIG_ON] && frame_start_o
      |-> {8'h0, gap} >= per) else $error("frames closer than period");
   ready_gate_a: assert property (!frame_ready_i [*3] |-> !frame_start_o)
      else $error("frame while pipeline busy");
   free_run_a: assert property ((ctrl[2:0] == 3'h1 && !ren && frame_ready_i) [*4]
      |-> frame_start_o) else $error("free run stalled");

   cover property (wait_acq_o && burst_start_o);
   cover property (ctrl[CTRL_FRM_TRIG_ON] && frame_start_o);
   cover property (ren && frame_start_o);
endmodule : acq_seq_properties

bind acquisition_trigger_sequencer acq_seq_properties i_props (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_waitrequest_o(avs_waitrequest_o), .trig_line_i(trig_line_i),
   .frame_ready_i(frame_ready_i), .frame_start_o(frame_start_o),
   .burst_start_o(burst_start_o), .wait_acq_o(wait_acq_o), .wait_frame_o(wait_frame_o));

/* sim/trig_source_model.sv */
`timescale 1ns/1ps
// ==========================================
// External sensing device on the trigger lines
module trig_source_model (
   // Clock
   input  wire logic       sys_clk_i,
   // Driven lines
   output logic [1:0]      trig_line_o
);
   initial trig_line_o = 2'h0;
   // One edge per wanted frame or burst; levels held two cycles or more for the synchroniser
   task automatic pulse(input int ln, input int hi, input int lo);
      @(posedge sys_clk_i);
      trig_line_o[ln] <= 1'b1;
      repeat (hi) @(posedge sys_clk_i);
      trig_line_o[ln] <= 1'b0;
      repeat (lo) @(posedge sys_clk_i);
   endtask : pulse
endmodule : trig_source_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import acq_seq_pkg::*;
   logic              sys_clk_i = 1'b0, rst_b_i, avs_read_i, avs_write_i, frame_ready_i;
   logic [ADDR_W-1:0] avs_address_i;
   logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o;
   logic [BE_W-1:0]   avs_byteenable_i;
   logic              avs_waitrequest_o, frame_start_o, burst_start_o, wait_acq_o, wait_frame_o;
   logic [LINES-1:0]  trig_line_i;
   logic [31:0]       exp_q[$];
   logic [31:0]       lfsr = 32'h6AC2DF77;
   int                err_count = 0, num_checks = 0, fcnt = 0, bcnt = 0, f0, b0, n, k;

   always #50 sys_clk_i = ~sys_clk_i;

   trig_source_model i_src (.sys_clk_i(sys_clk_i), .trig_line_o(trig_line_i));
   acquisition_trigger_sequencer i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .trig_line_i(trig_line_i), .frame_ready_i(frame_ready_i),
      .frame_start_o(frame_start_o), .burst_start_o(burst_start_o),
      .wait_acq_o(wait_acq_o), .wait_frame_o(wait_frame_o));

   // ==========================================
   // Helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Reads note the expected word; the monitor compares it
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= wr;
      avs_read_i      <= !wr;
      if (!wr) exp_q.push_back(d);
      // Only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge sys_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(posedge sys_clk_i);
   endtask : bus

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   always @(posedge sys_clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) check(avs_readdata_o, exp_q.pop_front());
      if (frame_start_o === 1'b1) fcnt++;
      if (burst_start_o === 1'b1) bcnt++;
   end

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_count++;
      finish_test();
   end

   // ==========================================
   // Tests
   initial begin
      rst_b_i = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 5'h00;
      avs_writedata_i = 32'h0;
      avs_byteenable_i = 4'hF;
      frame_ready_i = 1'b1;
      repeat (12) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
      bus(0, 5'h00, 32'h0);
      bus(0, 5'h04, 32'h1);
      bus(0, 5'h08, 32'h000F4240);
      bus(0, 5'h0C, 32'h4);
      bus(1, 5'h10, 32'hFFFF);
      bus(0, 5'h10, 32'h0);
      bus(0, 5'h14, 32'h0);
      // Narrow write: only the low byte lane may change
      avs_byteenable_i <= 4'h1;
      bus(1, 5'h04, 32'h00001234);
      avs_byteenable_i <= 4'hF;
      bus(0, 5'h04, 32'h34);
      $display("test registers done");
      // Burst on line 0, internal frames, random length, then paced
      lfsr = lfsr_next(lfsr);
      n = int'(lfsr[1:0]) + 1;
      bus(1, 5'h04, 32'(n));
      bus(1, 5'h00, 32'h3);
      f0 = fcnt;
      b0 = bcnt;
      i_src.pulse(0, 3, 20);
      check(fcnt - f0, n);
      check(bcnt - b0, 1);
      check(wait_acq_o, 1);
      bus(1, 5'h08, 32'h80000005);
      i_src.pulse(0, 2, 40);
      check(fcnt - f0, 2 * n);
      $display("test burst edge done");
      // Both stages on, frames on line 1
      bus(1, 5'h08, 32'h0);
      bus(1, 5'h04, 32'h3);
      bus(1, 5'h00, 32'h47);
      f0 = fcnt;
      i_src.pulse(1, 2, 6);
      check(fcnt - f0, 0);
      i_src.pulse(0, 2, 6);
      check(wait_frame_o, 1);
      repeat (4) i_src.pulse(1, 2, 3);
      check(fcnt - f0, 3);
      check(wait_acq_o, 1);
      $display("test both stages done");
      // Every activation code on the frame line, bursts internal
      bus(1, 5'h04, 32'h0);
      for (k = 0; k < 4; k++) begin
         bus(1, 5'h00, 32'h45 | (32'(k) << 7));
         f0 = fcnt;
         i_src.pulse(1, 3, 8);
         check(fcnt - f0, k == 2 ? 2 : (k == 3 ? 0 : 1));
      end
      $display("test activation done");
      // Free run: paced, unpaced, then a busy pipeline
      bus(1, 5'h00, 32'h0);
      bus(1, 5'h08, 32'h80000005);
      bus(1, 5'h00, 32'h1);
      f0 = fcnt;
      repeat (50) @(posedge sys_clk_i);
      check(fcnt - f0 >= 9 && fcnt - f0 <= 11, 1);
      bus(1, 5'h08, 32'h0);
      f0 = fcnt;
      repeat (20) @(posedge sys_clk_i);
      check(fcnt - f0 >= 18, 1);
      f0 = fcnt;
      n = 0;
      repeat (40) begin
         lfsr = lfsr_next(lfsr);
         frame_ready_i <= lfsr[0];
         n += int'(lfsr[0]);
         @(posedge sys_clk_i);
      end
      frame_ready_i <= 1'b1;
      check(fcnt - f0 + 2 >= n && fcnt - f0 <= n + 2, 1);
      bus(1, 5'h00, 32'h0);
      // Idle state lands one edge after the disable commits
      @(posedge sys_clk_i);
      check(wait_acq_o | wait_frame_o, 0);
      $display("test free run done");
      finish_test();
   end
endmodule : tb_top
